// ### hdl/cdr_cfg.svh
/*
  Address map, field positions and reset values of the camera pipeline
  configuration register bank. Assumes byte-wide registers on word-aligned
  Avalon-MM byte addresses (index times four).
*/
// Functional notes
// - knee compression bits 3:2 decode 11 half, 10 three-eighths, 01 quarter, 00 eighth.
// - bit 4 selects medium-resolution UV filter; bit 5 selects PAL over NTSC.
// - colour filter bit 0 enables false-colour lowpass, bit 1 progressive; bits 3:2 read zero.
// - white-clip bits 5:4: 1X pattern 11111, 01 pattern 01110, 00 pattern 00100.
// - false-colour conceal bits 7:6 pick the same three spreading patterns.
// - active-window high register gives bits 9:8 of four 10-bit window values.
// - vertical contour gain, 0 to 15, sits in bits 3:0.
// - contour coefficient 0 to 7 in bits 6:4; bit 7 enables horizontal contour filter.
// - gain select bit 0: 1 normal, 0 doubled; bits 7:1 reserved zero.
// - CIF filter: luma bits 1:0, chroma 3:2; 1X quarter, 01 half, 00 bypass.
// - line-reference stop high bits 1:0 extend stop position; bits 7:2 read zero.
// - scaler bits 2:0 pass, /2../32, 11X reserved; bit 3 field versus frame sync.
`ifndef CDR_CFG_SVH
`define CDR_CFG_SVH

// -----------------------------------------------------------------
// register indices
// -----------------------------------------------------------------
`define CDR_IDX_SENSOR   7'h00
`define CDR_IDX_KNEE     7'h01
`define CDR_IDX_COLOUR   7'h02
`define CDR_IDX_WIN_HI   7'h2f
`define CDR_IDX_VCONT    7'h31
`define CDR_IDX_GAINSEL  7'h3d
`define CDR_IDX_CIF      7'h3e
`define CDR_IDX_HSTOP_HI 7'h41
`define CDR_IDX_MEAS     7'h4b

// -----------------------------------------------------------------
// writable-bit masks (reserved bits stay zero)
// -----------------------------------------------------------------
`define CDR_MASK_SENSOR   8'h3f
`define CDR_MASK_KNEE     8'h3c
`define CDR_MASK_COLOUR   8'hf3
`define CDR_MASK_WIN_HI   8'hff
`define CDR_MASK_VCONT    8'hff
`define CDR_MASK_GAINSEL  8'h01
`define CDR_MASK_CIF      8'h0f
`define CDR_MASK_HSTOP_HI 8'h03
`define CDR_MASK_MEAS     8'h0f

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define CDR_RST_BYTE     8'h00
`define CDR_RST_GAINSEL  8'h01

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define CDR_KNEE_LSB     2
`define CDR_UVRES_BIT    4
`define CDR_STD_BIT      5
`define CDR_FCLP_BIT     0
`define CDR_PROG_BIT     1
`define CDR_WCLIP_LSB    4
`define CDR_FCONC_LSB    6
`define CDR_VGAIN_LSB    0
`define CDR_VCOEF_LSB    4
`define CDR_HCONT_BIT    7
`define CDR_LUMA_LSB     0
`define CDR_CHROMA_LSB   2
`define CDR_MSCALE_LSB   0
`define CDR_MSYNC_BIT    3
`define CDR_GAINSEL_BIT 0
`define CDR_HSTOP_LSB 0
`define CDR_WIN_W 2
`define CDR_WIN_FIELDS 4

// -----------------------------------------------------------------
// patterns and bus answer
// -----------------------------------------------------------------
`define CDR_SPREAD_WIDE  5'h1f
`define CDR_SPREAD_MID   5'h0e
`define CDR_SPREAD_ONE   5'h04
`define CDR_SPREAD_N_WIDE 3'h5
`define CDR_SPREAD_N_MID 3'h3
`define CDR_SPREAD_N_ONE 3'h1
`define CDR_SCALE_MAX    3'h5
`define CDR_UNMAPPED     32'h0000_0000

`endif

// ### hdl/cdr_pkg.sv
/*
  Types for the camera pipeline configuration bank.
  Assumes cdr_cfg.svh for the numeric values.
*/
package cdr_pkg;
  // knee compression factor, one-hot from eighth in bit 0 to half in bit 3
  typedef enum logic [3:0] {
    CDR_KNEE_EIGHTH = 4'b0001,
    CDR_KNEE_QUARTER = 4'b0010,
    CDR_KNEE_3EIGHTH = 4'b0100,
    CDR_KNEE_HALF = 4'b1000
  } cdr_knee_t;

  // bandwidth of a CIF horizontal filter
  typedef enum logic [2:0] {
    CDR_BW_FULL = 3'b001,
    CDR_BW_HALF = 3'b010,
    CDR_BW_QUARTER = 3'b100
  } cdr_bw_t;
endpackage

// ### hdl/cdr_spread_decode.sv
/*
  Decodes a two-bit spreading-mapping field into its five-tap pattern and
  the number of UV samples affected. Purely combinational.
*/
`timescale 1ns/1ps
`include "cdr_cfg.svh"
module cdr_spread_decode (
  // field in
  input wire logic [1:0] code,
  // decoded pattern
  output logic [4:0] pattern,
  output logic [2:0] samples
);
  import cdr_pkg::*;

  // upper bit dominates, so 1X is one case
  always_comb begin
    if (code[1]) begin
      pattern = `CDR_SPREAD_WIDE;
      samples = `CDR_SPREAD_N_WIDE;
    end else if (code[0]) begin
      pattern = `CDR_SPREAD_MID;
      samples = `CDR_SPREAD_N_MID;
    end else begin
      pattern = `CDR_SPREAD_ONE;
      samples = `CDR_SPREAD_N_ONE;
    end
  end
endmodule

// ### hdl/cdr_bw_decode.sv
/*
  Decodes a two-bit CIF horizontal filter field into a one-hot bandwidth.
*/
`timescale 1ns/1ps
`include "cdr_cfg.svh"
module cdr_bw_decode (
  // field in
  input wire logic [1:0] code,
  // decoded bandwidth
  output cdr_pkg::cdr_bw_t bw
);
  import cdr_pkg::*;

  // 1X quarter, 01 half, 00 bypass
  always_comb begin
    if (code[1]) begin
      bw = CDR_BW_QUARTER;
    end else if (code[0]) begin
      bw = CDR_BW_HALF;
    end else begin
      bw = CDR_BW_FULL;
    end
  end
endmodule

// ### hdl/cdr_config_regs.sv
/*
  Byte-wide configuration bank for the camera signal pipeline, reached over
  Avalon-MM. Decoded fields are driven to the pipeline as registered levels.
  Assumes one clock, asynchronous active-high reset, and a master that
  holds its request until waitrequest is seen low.
*/
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "cdr_cfg.svh"
module cdr_config_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // sensor setup
  output logic [7:0] sensor_setup,
  // knee and video
  output cdr_pkg::cdr_knee_t knee_compression,
  output logic uv_filter_resolution_sel,
  output logic video_standard_sel,
  // colour filter
  output logic false_colour_lowpass_en,
  output logic progressive_sel,
  output logic [4:0] white_clip_pattern,
  output logic [2:0] white_clip_samples,
  output logic [4:0] false_colour_conceal_pattern,
  output logic [2:0] false_colour_conceal_samples,
  // window high bits
  output logic [1:0] active_pixel_high,
  output logic [1:0] field0_last_line_high,
  output logic [1:0] field1_first_line_high,
  output logic [1:0] field1_last_line_high,
  // contour
  output logic [3:0] contour_gain,
  output logic [2:0] contour_coefficient,
  output logic hcontour_en,
  output logic contour_gain_double,
  // cif filters
  output cdr_pkg::cdr_bw_t cif_luma_bw,
  output cdr_pkg::cdr_bw_t cif_chroma_bw,
  // line reference stop
  output logic [1:0] line_ref_stop_high,
  // measurement engine
  output logic [2:0] measurement_engine_scale_shift,
  output logic measurement_engine_scale_valid,
  output logic measurement_engine_field_sync
);
  import cdr_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] knee_video_config;
  logic [7:0] colour_filter_config;
  logic [7:0] active_window_high_bits;
  logic [7:0] vertical_contour_config;
  logic [7:0] contour_gain_select;
  logic [7:0] cif_hfilter_config;
  logic [7:0] line_ref_stop_high_bits;
  logic [7:0] measure_engine_config;
  logic ack;
  logic [6:0] idx;
  logic wr_hit;
  logic [7:0] wbyte;
  logic [1:0] wclip_code;
  logic [1:0] fconc_code;
  logic [4:0] next_wclip_pattern;
  logic [2:0] next_wclip_samples;
  logic [4:0] next_fconc_pattern;
  logic [2:0] next_fconc_samples;
  cdr_bw_t next_luma_bw;
  cdr_bw_t next_chroma_bw;
  cdr_knee_t next_knee;
  logic [7:0] next_rdata;
  logic hit;

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  // byte address to register index; bits 1:0 are ignored (word aligned)
  assign idx = avs_address[8:2];
  // only lane 0 carries data, upper lanes are dropped
  assign wbyte = avs_writedata[7:0];
  assign wr_hit = avs_write & ~ack & avs_byteenable[0];

  // one wait state per access keeps read data registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack;

  // ---------------------------------------------------------------
  // register writes, masked so reserved bits stay zero
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sensor_setup <= `CDR_RST_BYTE;
      knee_video_config <= `CDR_RST_BYTE;
      colour_filter_config <= `CDR_RST_BYTE;
      active_window_high_bits <= `CDR_RST_BYTE;
      vertical_contour_config <= `CDR_RST_BYTE;
      contour_gain_select <= `CDR_RST_GAINSEL;
      cif_hfilter_config <= `CDR_RST_BYTE;
      line_ref_stop_high_bits <= `CDR_RST_BYTE;
      measure_engine_config <= `CDR_RST_BYTE;
    end else if (wr_hit) begin
      case (idx)
        `CDR_IDX_SENSOR: begin
          sensor_setup <= wbyte & `CDR_MASK_SENSOR;
        end
        `CDR_IDX_KNEE: begin
          knee_video_config <= wbyte & `CDR_MASK_KNEE;
        end
        `CDR_IDX_COLOUR: begin
          colour_filter_config <= wbyte & `CDR_MASK_COLOUR;
        end
        `CDR_IDX_WIN_HI: begin
          active_window_high_bits <= wbyte & `CDR_MASK_WIN_HI;
        end
        `CDR_IDX_VCONT: begin
          vertical_contour_config <= wbyte & `CDR_MASK_VCONT;
        end
        `CDR_IDX_GAINSEL: begin
          contour_gain_select <= wbyte & `CDR_MASK_GAINSEL;
        end
        `CDR_IDX_CIF: begin
          cif_hfilter_config <= wbyte & `CDR_MASK_CIF;
        end
        `CDR_IDX_HSTOP_HI: begin
          line_ref_stop_high_bits <= wbyte & `CDR_MASK_HSTOP_HI;
        end
        `CDR_IDX_MEAS: begin
          measure_engine_config <= wbyte & `CDR_MASK_MEAS;
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    hit = 1'b1;
    next_rdata = `CDR_RST_BYTE;
    case (idx)
      `CDR_IDX_SENSOR: next_rdata = sensor_setup;
      `CDR_IDX_KNEE: next_rdata = knee_video_config;
      `CDR_IDX_COLOUR: next_rdata = colour_filter_config;
      `CDR_IDX_WIN_HI: next_rdata = active_window_high_bits;
      `CDR_IDX_VCONT: next_rdata = vertical_contour_config;
      `CDR_IDX_GAINSEL: next_rdata = contour_gain_select;
      `CDR_IDX_CIF: next_rdata = cif_hfilter_config;
      `CDR_IDX_HSTOP_HI: next_rdata = line_ref_stop_high_bits;
      `CDR_IDX_MEAS: next_rdata = measure_engine_config;
      default: hit = 1'b0;
    endcase
  end

  // unmapped reads answer zero rather than stall the bus
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= `CDR_UNMAPPED;
    end else if (avs_read & ~ack) begin
      avs_readdata <= hit ? {24'h00_0000, next_rdata} : `CDR_UNMAPPED;
    end
  end

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  // knee factor, one-hot so the pipeline needs no decoder of its own
  always_comb begin
    unique case (knee_video_config[`CDR_KNEE_LSB +: 2])
      2'b11: next_knee = CDR_KNEE_HALF;
      2'b10: next_knee = CDR_KNEE_3EIGHTH;
      2'b01: next_knee = CDR_KNEE_QUARTER;
      2'b00: next_knee = CDR_KNEE_EIGHTH;
    endcase
  end

  assign wclip_code = colour_filter_config[`CDR_WCLIP_LSB +: 2];
  assign fconc_code = colour_filter_config[`CDR_FCONC_LSB +: 2];

  // white clip and concealment share one decoder design
  cdr_spread_decode u_wclip (
    .code(wclip_code),
    .pattern(next_wclip_pattern),
    .samples(next_wclip_samples)
  );

  cdr_spread_decode u_fconc (
    .code(fconc_code),
    .pattern(next_fconc_pattern),
    .samples(next_fconc_samples)
  );

  cdr_bw_decode u_luma (
    .code(cif_hfilter_config[`CDR_LUMA_LSB +: 2]),
    .bw(next_luma_bw)
  );

  cdr_bw_decode u_chroma (
    .code(cif_hfilter_config[`CDR_CHROMA_LSB +: 2]),
    .bw(next_chroma_bw)
  );

  // ---------------------------------------------------------------
  // registered pipeline controls
  // ---------------------------------------------------------------
  // video format and filters; one cycle behind the register write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      knee_compression <= CDR_KNEE_EIGHTH;
      uv_filter_resolution_sel <= 1'b0;
      video_standard_sel <= 1'b0;
      false_colour_lowpass_en <= 1'b0;
      progressive_sel <= 1'b0;
      white_clip_pattern <= `CDR_SPREAD_ONE;
      white_clip_samples <= `CDR_SPREAD_N_ONE;
      false_colour_conceal_pattern <= `CDR_SPREAD_ONE;
      false_colour_conceal_samples <= `CDR_SPREAD_N_ONE;
    end else begin
      knee_compression <= next_knee;
      uv_filter_resolution_sel <= knee_video_config[`CDR_UVRES_BIT];
      video_standard_sel <= knee_video_config[`CDR_STD_BIT];
      false_colour_lowpass_en <= colour_filter_config[`CDR_FCLP_BIT];
      progressive_sel <= colour_filter_config[`CDR_PROG_BIT];
      white_clip_pattern <= next_wclip_pattern;
      white_clip_samples <= next_wclip_samples;
      false_colour_conceal_pattern <= next_fconc_pattern;
      false_colour_conceal_samples <= next_fconc_samples;
    end
  end

  // contour, cif and line stop settings
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      contour_gain <= 4'h0;
      contour_coefficient <= 3'h0;
      hcontour_en <= 1'b0;
      contour_gain_double <= 1'b0;
      cif_luma_bw <= CDR_BW_FULL;
      cif_chroma_bw <= CDR_BW_FULL;
      line_ref_stop_high <= 2'h0;
    end else begin
      contour_gain <= vertical_contour_config[`CDR_VGAIN_LSB +: 4];
      contour_coefficient <= vertical_contour_config[`CDR_VCOEF_LSB +: 3];
      hcontour_en <= vertical_contour_config[`CDR_HCONT_BIT];
      contour_gain_double <= ~contour_gain_select[`CDR_GAINSEL_BIT];
      cif_luma_bw <= next_luma_bw;
      cif_chroma_bw <= next_chroma_bw;
      line_ref_stop_high <= line_ref_stop_high_bits[`CDR_HSTOP_LSB +: 2];
    end
  end

  // the four window extensions share one layout, two bits each, lowest value first
  logic [1:0] win_high [`CDR_WIN_FIELDS];
  for (genvar g = 0; g < `CDR_WIN_FIELDS; g++) begin : g_win
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        win_high[g] <= 2'h0;
      end else begin
        win_high[g] <= active_window_high_bits[g * `CDR_WIN_W +: `CDR_WIN_W];
      end
    end
  end

  // fixed order: pixel, field-0 last, field-1 first, field-1 last
  assign active_pixel_high = win_high[0];
  assign field0_last_line_high = win_high[1];
  assign field1_first_line_high = win_high[2];
  assign field1_last_line_high = win_high[3];

  // measurement scaler as a right-shift count; reserved codes flagged
  // invalid and treated as pass-through so a bad write cannot blow up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      measurement_engine_scale_shift <= 3'h0;
      measurement_engine_scale_valid <= 1'b1;
      measurement_engine_field_sync <= 1'b0;
    end else begin
      if (measure_engine_config[`CDR_MSCALE_LSB +: 3] > `CDR_SCALE_MAX) begin
        measurement_engine_scale_shift <= 3'h0;
        measurement_engine_scale_valid <= 1'b0;
      end else begin
        measurement_engine_scale_shift <= measure_engine_config[`CDR_MSCALE_LSB +: 3];
        measurement_engine_scale_valid <= 1'b1;
      end
      measurement_engine_field_sync <= measure_engine_config[`CDR_MSYNC_BIT];
    end
  end
endmodule

// ### dv/cdr_regs_assertions.sv
/*
  Checker for the camera configuration bank: bus wait state and field decode.
  Assumes it is bound to cdr_config_regs and sees only that module's ports.
*/
`timescale 1ns/1ps
`include "cdr_cfg.svh"
module cdr_regs_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // decoded fields
  input wire cdr_pkg::cdr_knee_t knee_compression,
  input wire logic uv_filter_resolution_sel,
  input wire logic video_standard_sel,
  input wire logic false_colour_lowpass_en,
  input wire logic progressive_sel,
  input wire logic [4:0] white_clip_pattern,
  input wire logic [2:0] white_clip_samples,
  input wire logic [4:0] false_colour_conceal_pattern,
  input wire logic [2:0] false_colour_conceal_samples,
  input wire logic [1:0] active_pixel_high,
  input wire logic [1:0] field0_last_line_high,
  input wire logic [1:0] field1_first_line_high,
  input wire logic [1:0] field1_last_line_high,
  input wire logic [3:0] contour_gain,
  input wire logic [2:0] contour_coefficient,
  input wire logic hcontour_en,
  input wire logic contour_gain_double,
  input wire cdr_pkg::cdr_bw_t cif_luma_bw,
  input wire cdr_pkg::cdr_bw_t cif_chroma_bw,
  input wire logic [1:0] line_ref_stop_high,
  input wire logic [2:0] measurement_engine_scale_shift,
  input wire logic measurement_engine_scale_valid,
  input wire logic measurement_engine_field_sync
);
  import cdr_pkg::*;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] d1, d;
  // write data delayed two edges, lines up with the field update
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      d1 <= 8'h00;
      d <= 8'h00;
    end else begin
      d1 <= avs_writedata[7:0];
      d <= d1;
    end
  end
  // samples and pattern of a spreading field
  function automatic logic [7:0] spr(input logic [1:0] c);
    return c[1] ? {3'h5, 5'h1f} : (c[0] ? {3'h3, 5'h0e} : {3'h1, 5'h04});
  endfunction
  function automatic logic [2:0] bw(input logic [1:0] c);
    return c[1] ? 3'h4 : (c[0] ? 3'h2 : 3'h1);
  endfunction
  sequence s_take;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_wr(logic [6:0] idx);
    s_take ##0 avs_write && avs_byteenable[0] && avs_address[8:2] == idx;
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_one_wait: assert property (s_take |=> !avs_waitrequest)
    else $error("access not answered after one wait state");
  a_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper lanes not zero");
  a_knee_decode: assert property (s_wr(`CDR_IDX_KNEE) |-> ##2 knee_compression == 4'h1 << d[3:2])
    else $error("knee factor decode wrong");
  a_video_sel: assert property (s_wr(`CDR_IDX_KNEE) |-> ##2 {video_standard_sel, uv_filter_resolution_sel} == d[5:4])
    else $error("video standard or uv filter select wrong");
  a_colour_flags: assert property (s_wr(`CDR_IDX_COLOUR) |-> ##2 {progressive_sel, false_colour_lowpass_en} == d[1:0])
    else $error("colour filter flags wrong");
  a_spread_decode: assert property (s_wr(`CDR_IDX_COLOUR) |-> ##2
    {white_clip_samples, white_clip_pattern} == spr(d[5:4])
    && {false_colour_conceal_samples, false_colour_conceal_pattern} == spr(d[7:6]))
    else $error("spreading pattern decode wrong");
  a_window_high: assert property (s_wr(`CDR_IDX_WIN_HI) |-> ##2
    {field1_last_line_high, field1_first_line_high, field0_last_line_high, active_pixel_high} == d)
    else $error("window high bits wrong");
  a_contour_fields: assert property (s_wr(`CDR_IDX_VCONT) |-> ##2 {hcontour_en, contour_coefficient, contour_gain} == d)
    else $error("vertical contour fields wrong");
  a_gain_double: assert property (s_wr(`CDR_IDX_GAINSEL) |-> ##2 contour_gain_double == !d[0])
    else $error("contour gain doubling wrong");
  a_cif_bw: assert property (s_wr(`CDR_IDX_CIF) |-> ##2 {cif_chroma_bw, cif_luma_bw} == {bw(d[3:2]), bw(d[1:0])})
    else $error("cif filter bandwidth wrong");
  a_stop_high: assert property (s_wr(`CDR_IDX_HSTOP_HI) |-> ##2 line_ref_stop_high == d[1:0])
    else $error("line stop high bits wrong");
  a_meas_scale: assert property (s_wr(`CDR_IDX_MEAS) |-> ##2 measurement_engine_field_sync == d[3]
    && measurement_engine_scale_valid == (d[2:1] != 2'h3)
    && measurement_engine_scale_shift == ((d[2:1] == 2'h3) ? 3'h0 : d[2:0]))
    else $error("measurement scaler decode wrong");
endmodule
bind cdr_config_regs cdr_regs_assertions chk_u (.*);

// ### dv/cdr_config_regs_tb.sv
/*
  Self-checking bench for the camera configuration bank, with a byte model.
  Assumes the design answers each Avalon-MM access after one wait state.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module cdr_config_regs_tb;
  import cdr_pkg::*;
  // ---------------------------------------------------------------
  // signals and model
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] avs_address = 9'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, uv_filter_resolution_sel, video_standard_sel, false_colour_lowpass_en, progressive_sel;
  logic [7:0] sensor_setup;
  cdr_knee_t knee_compression;
  logic [4:0] white_clip_pattern, false_colour_conceal_pattern;
  logic [2:0] white_clip_samples, false_colour_conceal_samples, contour_coefficient, measurement_engine_scale_shift;
  logic [1:0] active_pixel_high, field0_last_line_high, field1_first_line_high, field1_last_line_high;
  logic [1:0] line_ref_stop_high;
  logic [3:0] contour_gain;
  logic hcontour_en, contour_gain_double, measurement_engine_scale_valid, measurement_engine_field_sync;
  cdr_bw_t cif_luma_bw, cif_chroma_bw;
  logic [7:0] mdl [0:127];
  logic [6:0] regs [9] = '{7'h00, 7'h01, 7'h02, 7'h2f, 7'h31, 7'h3d, 7'h3e, 7'h41, 7'h4b};
  int n_fail = 0;
  int samples_checked = 0;

  cdr_config_regs dut_u (.*);

  // 250 MHz clock
  initial forever #2 clk = ~clk;

  // writable bits; zero marks an unmapped place
  function automatic logic [7:0] mask(input logic [6:0] i);
    case (i)
      7'h00: return 8'h3f;
      7'h01: return 8'h3c;
      7'h02: return 8'hf3;
      7'h2f, 7'h31: return 8'hff;
      7'h3d: return 8'h01;
      7'h3e, 7'h4b: return 8'h0f;
      7'h41: return 8'h03;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] spr(input logic [1:0] c);
    return c[1] ? {3'h5, 5'h1f} : (c[0] ? {3'h3, 5'h0e} : {3'h1, 5'h04});
  endfunction
  function automatic logic [2:0] bw(input logic [1:0] c);
    return c[1] ? 3'h4 : (c[0] ? 3'h2 : 3'h1);
  endfunction
  task automatic stop_test;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one access; request left up so the next may follow back to back
  task automatic acc(input logic wr, input logic [6:0] i, input logic [7:0] v, input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= {i, 2'($urandom)};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'($urandom), v};
    avs_byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_fail++;
      stop_test();
    end
    if (wr && be[0] && mask(i) != 8'h00) mdl[i] = v & mask(i);
    if (!wr) `CHK("readdata", {24'h0, mdl[i]}, avs_readdata)
  endtask
  task automatic idle;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (mdl[k]) mdl[k] = 8'h00;
    mdl[7'h3d] = 8'h01;
    @(posedge clk);
  endtask
  // every field output against the model
  task automatic check_all;
    logic [7:0] k, c, m, w, q;
    k = mdl[1];
    c = mdl[2];
    m = mdl[7'h4b];
    q = mdl[7'h3e];
    w = {field1_last_line_high, field1_first_line_high, field0_last_line_high, active_pixel_high};
    `CHK("sensor", mdl[0], sensor_setup)
    `CHK("knee", 4'h1 << k[3:2], knee_compression)
    `CHK("video", k[5:4], {video_standard_sel, uv_filter_resolution_sel})
    `CHK("flags", c[1:0], {progressive_sel, false_colour_lowpass_en})
    `CHK("wclip", spr(c[5:4]), {white_clip_samples, white_clip_pattern})
    `CHK("fconc", spr(c[7:6]), {false_colour_conceal_samples, false_colour_conceal_pattern})
    `CHK("window", mdl[7'h2f], w)
    `CHK("contour", mdl[7'h31], {hcontour_en, contour_coefficient, contour_gain})
    `CHK("double", !mdl[7'h3d][0], contour_gain_double)
    `CHK("cif", {bw(q[3:2]), bw(q[1:0])}, {cif_chroma_bw, cif_luma_bw})
    `CHK("stop", mdl[7'h41][1:0], line_ref_stop_high)
    `CHK("sync", m[3], measurement_engine_field_sync)
    `CHK("scale", (m[2:1] == 2'h3) ? 4'h0 : {1'b1, m[2:0]}, {measurement_engine_scale_valid, measurement_engine_scale_shift})
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32));
    do_reset();
    check_all();
    foreach (regs[j]) acc(1'b0, regs[j], 8'h00, 4'h1);
    // every code of every field, back-to-back writes then reads
    for (int v = 0; v < 16; v++) begin
      foreach (regs[j]) acc(1'b1, regs[j], {v[3:0], v[3:0]}, 4'hf);
      foreach (regs[j]) acc(1'b0, regs[j], 8'h00, 4'h0);
      idle();
      check_all();
    end
    // unmapped place: write ignored, read gives zero
    acc(1'b1, 7'h7e, 8'hff, 4'hf);
    acc(1'b0, 7'h7e, 8'h00, 4'hf);
    // random mix, lane-0 enable sometimes off
    for (int t = 0; t < 240; t++) begin
      acc(1'($urandom), ($urandom % 4 == 0) ? 7'($urandom) : regs[$urandom % 9], 8'($urandom), 4'($urandom));
      if (t % 8 == 7) begin
        idle();
        check_all();
      end
    end
    // reset in mid-run with every register loaded
    foreach (regs[j]) acc(1'b1, regs[j], 8'hff, 4'h1);
    idle();
    check_all();
    do_reset();
    check_all();
    foreach (regs[j]) acc(1'b0, regs[j], 8'h00, 4'h1);
    idle();
    stop_test();
  end
endmodule
